// ---- design/battery_tag_cmd_decoder.sv ----
`timescale 1ns/1ps
`default_nettype none
module battery_tag_cmd_decoder #(
    parameter logic [23:0] NV_WRITE_CYCLES = 24'(tag_pkg::NV_WRITE_COUNT),
    parameter logic [23:0] CONV_CYCLES = 24'(tag_pkg::CONV_COUNT),
    parameter logic [15:0] ID_VALUE = tag_pkg::ID_DEFAULT
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Byte link from the bit-slot layer
    input wire logic bus_reset,
    input wire logic rx_valid,
    input wire logic [tag_pkg::BYTE_W-1:0] rx_data,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [tag_pkg::BYTE_W-1:0] tx_data,
    // Temperature sensor result in half degrees
    input wire logic [tag_pkg::TEMP_W-1:0] temp_sample,
    // Status
    output tag_pkg::status_type status_flags
);
    import tag_pkg::*;

    state_type state_reg;
    state_type state_next;
    logic [7:0] cmd_reg;
    logic [7:0] cmd_next;
    logic [7:0] addr_reg;
    logic [7:0] addr_next;
    logic [7:0] end_reg;
    logic [7:0] end_next;
    logic [7:0] scratch_reg [0:SCRATCH_DEPTH-1];
    logic [7:0] scratch_next [0:SCRATCH_DEPTH-1];
    logic [7:0] eeprom_a_reg [0:PAGE_A_LEN-1];
    logic [7:0] eeprom_a_next [0:PAGE_A_LEN-1];
    logic [7:0] eeprom_b_reg [0:PAGE_B_LEN-1];
    logic [7:0] eeprom_b_next [0:PAGE_B_LEN-1];
    logic [7:0] sram_reg [0:PAGE_C_LEN-1];
    logic [7:0] sram_next [0:PAGE_C_LEN-1];
    logic lock_reg;
    logic lock_next;
    logic [COUNT_W-1:0] count_reg;
    logic [COUNT_W-1:0] count_next;
    logic nv_busy_reg;
    logic nv_busy_next;
    logic [TIMER_W-1:0] nv_timer_reg;
    logic [TIMER_W-1:0] nv_timer_next;
    logic t_busy_reg;
    logic t_busy_next;
    logic [TIMER_W-1:0] t_timer_reg;
    logic [TIMER_W-1:0] t_timer_next;
    logic [TEMP_W-1:0] temp_reg;
    logic [TEMP_W-1:0] temp_next;
    logic push;
    logic flush;
    logic fifo_ready;
    logic [7:0] push_data;
    logic nv_start;
    logic cmd_take;
    status_type status_now;

    function automatic logic scratch_ok(input logic [7:0] a);
        scratch_ok = (a < PAGE_A_BASE + PAGE_A_LEN)
            || (a >= PAGE_B_BASE && a < PAGE_B_BASE + PAGE_B_LEN)
            || (a >= PAGE_C_BASE && a <= SCRATCH_LAST);
    endfunction

    assign status_now = '{reserved: '0, lock: lock_reg,
        eeprom_busy_flag: nv_busy_reg, temp_busy_flag: t_busy_reg};
    assign status_flags = status_now;
    assign cmd_take = rx_valid && !bus_reset && state_reg == ST_CMD;

    // Read data for the current address; gaps and addresses past the end
    // answer all ones.
    always_comb
    begin
        push_data = BYTE_ONES;
        if (addr_reg <= end_reg)
        begin
            if (cmd_reg == CMD_READ_SCRATCH)
            begin
                if (scratch_ok(addr_reg))
                    push_data = scratch_reg[addr_reg[6:0]];
            end
            else
            begin
                unique case (addr_reg)
                    REG_TEMP_HALF: push_data = temp_reg[7:0];
                    REG_TEMP_WHOLE: push_data = temp_reg[8:1];
                    REG_STATUS: push_data = status_now;
                    REG_ID_LO: push_data = ID_VALUE[7:0];
                    REG_ID_HI: push_data = ID_VALUE[15:8];
                    REG_COUNT_LO: push_data = count_reg[7:0];
                    REG_COUNT_HI: push_data = count_reg[15:8];
                    default: push_data = BYTE_ONES;
                endcase
            end
        end
    end

    always_comb
    begin
        state_next = state_reg;
        cmd_next = cmd_reg;
        addr_next = addr_reg;
        end_next = end_reg;
        scratch_next = scratch_reg;
        eeprom_a_next = eeprom_a_reg;
        eeprom_b_next = eeprom_b_reg;
        sram_next = sram_reg;
        lock_next = lock_reg;
        count_next = count_reg;
        nv_busy_next = nv_busy_reg;
        nv_timer_next = nv_timer_reg;
        t_busy_next = t_busy_reg;
        t_timer_next = t_timer_reg;
        temp_next = temp_reg;
        push = 1'b0;
        flush = 1'b0;
        nv_start = 1'b0;
        if (nv_timer_reg != '0)
        begin
            nv_timer_next = nv_timer_reg - 1'b1;
            if (nv_timer_reg == TIMER_W'(1))
                nv_busy_next = 1'b0;
        end
        if (t_timer_reg != '0)
        begin
            t_timer_next = t_timer_reg - 1'b1;
            if (t_timer_reg == TIMER_W'(1))
            begin
                t_busy_next = 1'b0;
                temp_next = temp_sample;
            end
        end
        if (bus_reset)
        begin
            state_next = ST_CMD;
            flush = 1'b1;
        end
        else
        begin
            unique case (state_reg)
                ST_HALT, ST_IDLE:
                    state_next = state_reg;
                ST_CMD:
                    if (rx_valid)
                    begin
                        cmd_next = rx_data;
                        state_next = ST_IDLE;
                        case (rx_data)
                            CMD_READ_SCRATCH, CMD_WRITE_SCRATCH, CMD_READ_REGS:
                                state_next = ST_ADDR;
                            CMD_COPY_A_UP:
                                if (!nv_busy_reg && !lock_reg)
                                begin
                                    for (int i = 0; i < PAGE_A_LEN; i++)
                                        eeprom_a_next[i] = scratch_reg[PAGE_A_BASE + i];
                                    nv_start = 1'b1;
                                end
                            CMD_COPY_B_UP:
                                if (!nv_busy_reg)
                                begin
                                    for (int i = 0; i < PAGE_B_LEN; i++)
                                        eeprom_b_next[i] = scratch_reg[PAGE_B_BASE + i];
                                    nv_start = 1'b1;
                                end
                            CMD_COPY_C_SRAM:
                                for (int i = 0; i < PAGE_C_LEN; i++)
                                    sram_next[i] = scratch_reg[PAGE_C_BASE + i];
                            CMD_COPY_A_DOWN:
                                for (int i = 0; i < PAGE_A_LEN; i++)
                                    scratch_next[PAGE_A_BASE + i] = eeprom_a_reg[i];
                            CMD_COPY_B_DOWN:
                                for (int i = 0; i < PAGE_B_LEN; i++)
                                    scratch_next[PAGE_B_BASE + i] = eeprom_b_reg[i];
                            CMD_COPY_SRAM_C:
                                for (int i = 0; i < PAGE_C_LEN; i++)
                                    scratch_next[PAGE_C_BASE + i] = sram_reg[i];
                            CMD_LOCK:
                                if (!nv_busy_reg)
                                begin
                                    lock_next = 1'b1;
                                    nv_start = 1'b1;
                                end
                            CMD_UNLOCK:
                                if (!nv_busy_reg)
                                begin
                                    lock_next = 1'b0;
                                    nv_start = 1'b1;
                                end
                            CMD_COUNT_CLEAR:
                                if (!nv_busy_reg)
                                begin
                                    count_next = '0;
                                    nv_start = 1'b1;
                                end
                            CMD_COUNT_INC:
                                if (!nv_busy_reg)
                                begin
                                    count_next = count_reg + 1'b1;
                                    nv_start = 1'b1;
                                end
                            CMD_CONVERT:
                                if (!t_busy_reg)
                                begin
                                    t_busy_next = 1'b1;
                                    t_timer_next = CONV_CYCLES;
                                end
                            default:
                                state_next = ST_IDLE;
                        endcase
                    end
                ST_ADDR:
                    if (rx_valid)
                    begin
                        addr_next = rx_data;
                        end_next = SCRATCH_LAST;
                        if (cmd_reg == CMD_READ_REGS)
                        begin
                            if (rx_data <= REG_P4_LAST)
                                end_next = REG_P4_LAST;
                            else if (rx_data >= REG_ID_LO)
                                end_next = REG_COUNT_HI;
                            else
                                end_next = REG_NONE;
                        end
                        if (cmd_reg == CMD_WRITE_SCRATCH)
                            state_next = ST_WRITE;
                        else
                            state_next = ST_READ;
                    end
                ST_WRITE:
                    if (rx_valid)
                    begin
                        if (scratch_ok(addr_reg))
                            scratch_next[addr_reg[6:0]] = rx_data;
                        if (addr_reg != ADDR_MAX)
                            addr_next = addr_reg + 8'h01;
                    end
                ST_READ:
                    if (fifo_ready)
                    begin
                        push = 1'b1;
                        if (addr_reg != ADDR_MAX)
                            addr_next = addr_reg + 8'h01;
                    end
                default:
                    state_next = ST_HALT;
            endcase
        end
        if (nv_start)
        begin
            nv_busy_next = 1'b1;
            nv_timer_next = NV_WRITE_CYCLES;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= ST_HALT;
            cmd_reg <= '0;
            addr_reg <= '0;
            end_reg <= '0;
            scratch_reg <= '{default: '0};
            eeprom_a_reg <= '{default: '0};
            eeprom_b_reg <= '{default: '0};
            sram_reg <= '{default: '0};
            lock_reg <= 1'b0;
            count_reg <= '0;
            nv_busy_reg <= 1'b0;
            nv_timer_reg <= '0;
            t_busy_reg <= 1'b0;
            t_timer_reg <= '0;
            temp_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            cmd_reg <= cmd_next;
            addr_reg <= addr_next;
            end_reg <= end_next;
            scratch_reg <= scratch_next;
            eeprom_a_reg <= eeprom_a_next;
            eeprom_b_reg <= eeprom_b_next;
            sram_reg <= sram_next;
            lock_reg <= lock_next;
            count_reg <= count_next;
            nv_busy_reg <= nv_busy_next;
            nv_timer_reg <= nv_timer_next;
            t_busy_reg <= t_busy_next;
            t_timer_reg <= t_timer_next;
            temp_reg <= temp_next;
        end
    end

    // Bytes travel whole here; the slot layer shifts them out LSB first.
    byte_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) tx_fifo (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .flush(flush),
        .in_valid(push),
        .in_ready(fifo_ready),
        .in_data(push_data),
        .out_valid(tx_valid),
        .out_ready(tx_ready),
        .out_data(tx_data)
    );

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    chk_copy_busy: assert property (cmd_take && rx_data == CMD_COPY_A_UP
        && !nv_busy_reg && !lock_reg |=> nv_busy_reg [*8])
        else $error("eeprom busy not held after page copy");
    chk_lock_set: assert property (cmd_take && rx_data == CMD_LOCK
        && !nv_busy_reg |=> lock_reg && status_flags.eeprom_busy_flag)
        else $error("lock command did not lock");
    chk_unlock_clear: assert property (cmd_take && rx_data == CMD_UNLOCK
        && !nv_busy_reg |=> !lock_reg && nv_busy_reg)
        else $error("unlock command did not unlock");
    chk_count_clear: assert property (cmd_take && rx_data == CMD_COUNT_CLEAR
        && !nv_busy_reg |=> count_reg == '0 && nv_busy_reg)
        else $error("counter not cleared");
    chk_count_step: assert property (cmd_take && rx_data == CMD_COUNT_INC
        && !nv_busy_reg |=> count_reg == $past(count_reg) + 16'h0001)
        else $error("counter not incremented");
    chk_temp_busy: assert property (cmd_take && rx_data == CMD_CONVERT
        && !t_busy_reg |=> t_busy_reg && t_timer_reg == CONV_CYCLES)
        else $error("conversion did not raise busy");
    chk_locked_copy: assert property (cmd_take && rx_data == CMD_COPY_A_UP
        && lock_reg |=> eeprom_a_reg[0] == $past(eeprom_a_reg[0])
        && nv_busy_reg == $past(nv_busy_reg))
        else $error("locked page was copied");
    chk_read_ones: assert property (push && addr_reg > end_reg
        |-> push_data == BYTE_ONES)
        else $error("read past end not all ones");
    chk_write_store: assert property (state_reg == ST_WRITE && rx_valid
        && !bus_reset && scratch_ok(addr_reg)
        |=> scratch_reg[$past(addr_reg[6:0])] == $past(rx_data)
        && addr_reg == $past(addr_reg) + 8'h01)
        else $error("scratch write not stored");
    chk_busy_end: assert property (nv_busy_reg && nv_timer_reg == 24'h00_0001
        && !nv_start |=> !nv_busy_reg)
        else $error("eeprom busy did not clear");
endmodule
`default_nettype wire

// ---- design/byte_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic flush,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [PW:0] wr_reg;
    logic [PW:0] wr_next;
    logic [PW:0] rd_reg;
    logic [PW:0] rd_next;
    logic full;
    logic empty;
    logic do_wr;
    logic do_rd;

    assign empty = (wr_reg == rd_reg);
    assign full = (wr_reg[PW] != rd_reg[PW]) && (wr_reg[PW-1:0] == rd_reg[PW-1:0]);
    assign in_ready = !full && !flush;
    assign out_valid = !empty;
    assign out_data = mem[rd_reg[PW-1:0]];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;

    always_comb
    begin
        wr_next = wr_reg;
        rd_next = rd_reg;
        if (flush)
        begin
            wr_next = '0;
            rd_next = '0;
        end
        else
        begin
            if (do_wr)
                wr_next = wr_reg + 1'b1;
            if (do_rd)
                rd_next = rd_reg + 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_reg <= '0;
            rd_reg <= '0;
        end
        else
        begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
        end
    end

    // Storage needs no reset; the pointers decide what is valid.
    always_ff @(posedge ref_clk)
    begin
        if (do_wr)
            mem[wr_reg[PW-1:0]] <= in_data;
    end
endmodule
`default_nettype wire

// ---- inc/tag_pkg.sv ----
// Function
// - 11h plus address 00h-5Fh streams scratchpad bytes from there.
// - 17h plus address stores following bytes at consecutive addresses.
// - 22h and 25h copy scratch pages a, b to eeprom; busy about 10ms.
// - 28h copies scratch page c into SRAM; no address, bus idle after.
// - 71h and 77h copy eeprom pages a, b into scratch; bus idle after.
// - 7Ah copies SRAM into scratch page c; no address, bus idle after.
// - 43h sets the page a lock and raises eeprom busy until done.
// - 44h clears the page a lock and raises eeprom busy until done.
// - B2h plus address 60h-63h or 80h-83h streams register bytes.
// - B8h clears the cycle counter and raises eeprom busy until done.
// - B5h increments the cycle counter and raises eeprom busy until done.
// - D2h starts a conversion; temperature busy stays high until result.
// - Register 61h holds temperature, whole degrees, two's complement.
// - Eeprom busy reads one during an eeprom update, zero otherwise.
// - Reads past the end of scratchpad or register space return all ones.
// - Locked: page a copy to eeprom ignored; copy down still allowed.
package tag_pkg;
    localparam int BYTE_W = 8;
    localparam int TEMP_W = 9;
    localparam int COUNT_W = 16;
    localparam int TIMER_W = 24;
    localparam int FIFO_DEPTH = 16;

    localparam logic [7:0] CMD_READ_SCRATCH = 8'h11;
    localparam logic [7:0] CMD_WRITE_SCRATCH = 8'h17;
    localparam logic [7:0] CMD_COPY_A_UP = 8'h22;
    localparam logic [7:0] CMD_COPY_B_UP = 8'h25;
    localparam logic [7:0] CMD_COPY_C_SRAM = 8'h28;
    localparam logic [7:0] CMD_COPY_A_DOWN = 8'h71;
    localparam logic [7:0] CMD_COPY_B_DOWN = 8'h77;
    localparam logic [7:0] CMD_COPY_SRAM_C = 8'h7A;
    localparam logic [7:0] CMD_LOCK = 8'h43;
    localparam logic [7:0] CMD_UNLOCK = 8'h44;
    localparam logic [7:0] CMD_READ_REGS = 8'hB2;
    localparam logic [7:0] CMD_COUNT_CLEAR = 8'hB8;
    localparam logic [7:0] CMD_COUNT_INC = 8'hB5;
    localparam logic [7:0] CMD_CONVERT = 8'hD2;

    localparam int SCRATCH_DEPTH = 96;
    localparam logic [7:0] PAGE_A_BASE = 8'h00;
    localparam logic [7:0] PAGE_A_LEN = 8'h18;
    localparam logic [7:0] PAGE_B_BASE = 8'h20;
    localparam logic [7:0] PAGE_B_LEN = 8'h08;
    localparam logic [7:0] PAGE_C_BASE = 8'h40;
    localparam logic [7:0] PAGE_C_LEN = 8'h20;
    localparam logic [7:0] SCRATCH_LAST = 8'h5F;

    localparam logic [7:0] REG_TEMP_HALF = 8'h60;
    localparam logic [7:0] REG_TEMP_WHOLE = 8'h61;
    localparam logic [7:0] REG_STATUS = 8'h62;
    localparam logic [7:0] REG_P4_LAST = 8'h63;
    localparam logic [7:0] REG_ID_LO = 8'h80;
    localparam logic [7:0] REG_ID_HI = 8'h81;
    localparam logic [7:0] REG_COUNT_LO = 8'h82;
    localparam logic [7:0] REG_COUNT_HI = 8'h83;
    localparam logic [7:0] REG_NONE = 8'h00;
    localparam logic [7:0] BYTE_ONES = 8'hFF;
    localparam logic [7:0] ADDR_MAX = 8'hFF;

    // Identity value is arbitrary.
    localparam logic [15:0] ID_DEFAULT = 16'h5A5A;

    localparam int CLK_PERIOD_NS = 10;
    localparam int NV_WRITE_MS = 10;
    localparam int NV_WRITE_COUNT = NV_WRITE_MS * 1000000 / CLK_PERIOD_NS;
    localparam int CONV_COUNT = 4000;

    typedef enum logic [2:0] {
        ST_HALT = 3'b000,
        ST_CMD = 3'b001,
        ST_ADDR = 3'b010,
        ST_WRITE = 3'b011,
        ST_READ = 3'b100,
        ST_IDLE = 3'b101
    } state_type;

    typedef struct packed {
        logic [4:0] reserved;
        logic lock;
        logic eeprom_busy_flag;
        logic temp_busy_flag;
    } status_type;
endpackage

// ---- tb/battery_tag_cmd_decoder_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module battery_tag_cmd_decoder_tb_top;
    import tag_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n;
    logic bus_reset, rx_valid, tx_valid, tx_ready;
    logic [7:0] rx_data, tx_data;
    logic [8:0] temp_sample;
    status_type status_flags;
    int num_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    always #5 ref_clk = ~ref_clk;
    battery_tag_cmd_decoder #(.NV_WRITE_CYCLES(24'd50),
        .CONV_CYCLES(24'd20)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .bus_reset(bus_reset), .rx_valid(rx_valid), .rx_data(rx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
        .temp_sample(temp_sample), .status_flags(status_flags));
    tag_master mdl (.ref_clk(ref_clk), .bus_reset(bus_reset),
        .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_data(tx_data));
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            tally_and_finish();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] c);
        mdl.open_txn();
        mdl.send(c);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cmd(CMD_WRITE_SCRATCH);
        mdl.send(a);
        mdl.send(d);
    endtask
    task automatic rd1(input logic [7:0] c, input logic [7:0] a,
        output logic [7:0] b);
        cmd(c);
        mdl.send(a);
        mdl.recv(b);
    endtask
    // Polls the status byte, a fresh transaction each time.
    task automatic wait_idle();
        logic [7:0] s;
        for (int i = 0; i < 60; i++)
        begin
            rd1(CMD_READ_REGS, REG_STATUS, s);
            if (s[1:0] === 2'b00)
                return;
        end
        check(s, 8'h00);
    endtask
    task automatic t_stream();
        logic [7:0] b;
        cmd(CMD_WRITE_SCRATCH);
        mdl.send(8'h5E);
        mdl.send(8'h11);
        mdl.send(8'h22);
        cmd(CMD_READ_SCRATCH);
        mdl.send(8'h5E);
        repeat (24) @(negedge ref_clk);
        mdl.recv(b);
        check(b, 8'h11);
        mdl.recv(b);
        check(b, 8'h22);
        mdl.recv(b);
        check(b, BYTE_ONES);
        $display("test stream done");
    endtask
    task automatic copy_round(input logic [7:0] a, input logic [7:0] up,
        input logic [7:0] down, input logic [7:0] v);
        logic [7:0] b;
        wr(a, v);
        cmd(up);
        check({7'd0, status_flags.eeprom_busy_flag},
            {7'd0, up != CMD_COPY_C_SRAM});
        wait_idle();
        wr(a, ~v);
        cmd(down);
        rd1(CMD_READ_SCRATCH, a, b);
        check(b, v);
    endtask
    task automatic t_lock();
        logic [7:0] b;
        cmd(CMD_LOCK);
        check({7'd0, status_flags.eeprom_busy_flag}, 8'h01);
        wait_idle();
        check({7'd0, status_flags.lock}, 8'h01);
        wr(8'h00, 8'hAA);
        cmd(CMD_COPY_A_UP);
        check({7'd0, status_flags.eeprom_busy_flag}, 8'h00);
        cmd(CMD_COPY_A_DOWN);
        rd1(CMD_READ_SCRATCH, 8'h00, b);
        check(b, 8'h3C);
        cmd(CMD_UNLOCK);
        check({7'd0, status_flags.eeprom_busy_flag}, 8'h01);
        wait_idle();
        check({7'd0, status_flags.lock}, 8'h00);
        $display("test lock done");
    endtask
    task automatic t_counter();
        logic [7:0] b;
        logic [7:0] exp [5];
        exp = '{ID_DEFAULT[7:0], ID_DEFAULT[15:8], 8'h02, 8'h00, BYTE_ONES};
        repeat (2)
        begin
            cmd(CMD_COUNT_INC);
            check({7'd0, status_flags.eeprom_busy_flag}, 8'h01);
            wait_idle();
        end
        cmd(CMD_READ_REGS);
        mdl.send(REG_ID_LO);
        foreach (exp[i])
        begin
            mdl.recv(b);
            check(b, exp[i]);
        end
        cmd(CMD_COUNT_CLEAR);
        check({7'd0, status_flags.eeprom_busy_flag}, 8'h01);
        wait_idle();
        rd1(CMD_READ_REGS, REG_COUNT_LO, b);
        check(b, 8'h00);
        $display("test counter done");
    endtask
    task automatic t_temp();
        logic [7:0] b;
        temp_sample = 9'h1F6;
        cmd(CMD_CONVERT);
        check({7'd0, status_flags.temp_busy_flag}, 8'h01);
        wait_idle();
        rd1(CMD_READ_REGS, REG_TEMP_WHOLE, b);
        check(b, 8'hFB);
        rd1(CMD_READ_REGS, REG_TEMP_HALF, b);
        check(b, 8'hF6);
        $display("test temp done");
    endtask
    // Bytes after a no-address or unknown command, and repeated eeprom
    // commands while busy, must change nothing.
    task automatic t_refuse();
        logic [7:0] b;
        cmd(CMD_COPY_C_SRAM);
        mdl.send(CMD_COUNT_INC);
        check({7'd0, status_flags.eeprom_busy_flag}, 8'h00);
        cmd(8'h00);
        mdl.send(CMD_LOCK);
        check({7'd0, status_flags.lock}, 8'h00);
        cmd(CMD_COUNT_INC);
        cmd(CMD_COUNT_INC);
        wait_idle();
        rd1(CMD_READ_REGS, REG_COUNT_LO, b);
        check(b, 8'h01);
        $display("test refuse done");
    endtask
    // A reset in mid-run clears all state, and bytes before the first
    // bus reset are ignored.
    task automatic t_reset();
        logic [7:0] b;
        @(negedge ref_clk);
        rst_n = 1'b0;
        @(negedge ref_clk);
        check(status_flags, 8'h00);
        check({7'd0, tx_valid}, 8'h00);
        rst_n = 1'b1;
        mdl.send(CMD_COUNT_INC);
        check({7'd0, status_flags.eeprom_busy_flag}, 8'h00);
        rd1(CMD_READ_SCRATCH, 8'h40, b);
        check(b, 8'h00);
        rd1(CMD_READ_REGS, REG_COUNT_LO, b);
        check(b, 8'h00);
        $display("test reset done");
    endtask
    initial
    begin
        rst_n = 1'b0;
        temp_sample = 9'h000;
        repeat (8) @(negedge ref_clk);
        rst_n = 1'b1;
        t_stream();
        copy_round(8'h00, CMD_COPY_A_UP, CMD_COPY_A_DOWN, 8'h3C);
        copy_round(8'h20, CMD_COPY_B_UP, CMD_COPY_B_DOWN, 8'hC5);
        copy_round(8'h40, CMD_COPY_C_SRAM, CMD_COPY_SRAM_C, 8'h96);
        $display("test copy done");
        t_lock();
        t_counter();
        t_temp();
        t_refuse();
        t_reset();
        tally_and_finish();
    end
endmodule
`default_nettype wire

// ---- tb/tag_master.sv ----
`timescale 1ns/1ps
`default_nettype none
module tag_master (
    // Clock
    input wire logic ref_clk,
    // Byte link
    output logic bus_reset,
    output logic rx_valid,
    output logic [tag_pkg::BYTE_W-1:0] rx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [tag_pkg::BYTE_W-1:0] tx_data
);
    import tag_pkg::*;
    initial
    begin
        bus_reset = 1'b0;
        rx_valid = 1'b0;
        rx_data = 8'h00;
        tx_ready = 1'b0;
    end
    task automatic open_txn();
        @(negedge ref_clk);
        bus_reset = 1'b1;
        @(negedge ref_clk);
        bus_reset = 1'b0;
    endtask
    // A released data line shows the inverse of the last byte.
    task automatic send(input logic [7:0] b);
        @(negedge ref_clk);
        rx_valid = 1'b1;
        rx_data = b;
        @(negedge ref_clk);
        rx_valid = 1'b0;
        rx_data = ~b;
    endtask
    task automatic recv(output logic [7:0] b);
        b = 8'hxx;
        @(negedge ref_clk);
        tx_ready = 1'b1;
        for (int i = 0; i < 40; i++)
        begin
            @(posedge ref_clk);
            if (tx_valid === 1'b1)
            begin
                b = tx_data;
                break;
            end
        end
        @(negedge ref_clk);
        tx_ready = 1'b0;
    endtask
endmodule
`default_nettype wire
